// ---- sim/test_reload_capture_timer.sv ----
// Self-checking testbench of the reload and capture timer
`timescale 1ns/1ps
module test_reload_capture_timer;
   import reload_timer_pkg::*;

   // ****************************************************************
   // Signals and design instance
   // ****************************************************************
   logic        mclk, rst, psel, penable, pwrite, ext_clk;
   logic        frame_start, low_freq_osc, irq_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, timer_req, irq;
   logic [7:0]  rdat;
   logic        rerr;
   int          errors, n_compared;

   typedef struct {
      logic       w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] exp;
      logic       err;
   } row_t;

   reload_capture_timer dut (
      .mclk_i         (mclk),
      .rst_i          (rst),
      .psel_i         (psel),
      .penable_i      (penable),
      .pwrite_i       (pwrite),
      .paddr_i        (paddr),
      .pwdata_i       (pwdata),
      .pstrb_i        (4'hF),
      .ext_clk_i      (ext_clk),
      .frame_start_i  (frame_start),
      .low_freq_osc_i (low_freq_osc),
      .timer_irq_en_i (irq_en),
      .prdata_o       (prdata),
      .pready_o       (pready),
      .pslverr_o      (pslverr),
      .timer_req_o    (timer_req),
      .irq_o          (irq)
   );

   // ****************************************************************
   // Clocks
   // ****************************************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // External clock: falling edge every 4 system clocks
   initial begin
      ext_clk = 1'b0;
      forever begin
         repeat (2) @(posedge mclk);
         ext_clk <= ~ext_clk;
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         $display("MISMATCH t=%0t no bus answer", $time);
         end_of_test;
      end
      rdat = prdata[7:0];
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task wait_req(input int lim);
      int n;
      n = 0;
      while (timer_req !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
      if (n >= lim) begin
         errors++;
         $display("MISMATCH t=%0t request never rose", $time);
         end_of_test;
      end
   endtask

   task set_count(input logic [7:0] hi, input logic [7:0] lo);
      apb(1'b1, ADDR_COUNT_HI, hi);
      apb(1'b1, ADDR_COUNT_LO, lo);
   endtask

   // ****************************************************************
   // Register table rows
   // ****************************************************************
   row_t rows [19];
   initial begin
      rows = '{
         '{1'b0, ADDR_CTRL,       8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_RELOAD_LO,  8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_RELOAD_HI,  8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_COUNT_LO,   8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_COUNT_HI,   8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_CLKSEL,     8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_IRQ_STATUS, 8'h00, 8'h00, 1'b0},
         '{1'b0, ADDR_IRQ_MASK,   8'h00, 8'h00, 1'b0},
         '{1'b1, ADDR_RELOAD_LO,  8'h5A, 8'h00, 1'b0},
         '{1'b0, ADDR_RELOAD_LO,  8'h00, 8'h5A, 1'b0},
         '{1'b1, ADDR_RELOAD_HI,  8'hA5, 8'h00, 1'b0},
         '{1'b0, ADDR_RELOAD_HI,  8'h00, 8'hA5, 1'b0},
         '{1'b1, ADDR_COUNT_LO,   8'h3C, 8'h00, 1'b0},
         '{1'b0, ADDR_COUNT_LO,   8'h00, 8'h3C, 1'b0},
         '{1'b1, ADDR_CLKSEL,     8'h03, 8'h00, 1'b0},
         '{1'b0, ADDR_CLKSEL,     8'h00, 8'h03, 1'b0},
         '{1'b1, 8'hC0,           8'h77, 8'h00, 1'b1},
         '{1'b0, 8'hC0,           8'h00, 8'h00, 1'b1},
         '{1'b0, ADDR_IRQ_MASK,   8'h00, 8'h00, 1'b0}
      };
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      errors = 0;
      n_compared = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      frame_start = 1'b0;
      low_freq_osc = 1'b0;
      irq_en = 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);

      // Reset values, read-back and unmapped place
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rdat, rows[i].exp);
         chk({7'h00, rerr}, {7'h00, rows[i].err});
      end
      $display("test registers done");

      // 16-bit reload on system clock, masked then unmasked
      apb(1'b1, ADDR_RELOAD_LO, 8'h34);
      apb(1'b1, ADDR_RELOAD_HI, 8'h12);
      set_count(8'hFF, 8'hFC);
      apb(1'b1, ADDR_CTRL, 8'h04);
      wait_req(50);
      chk({7'h00, irq}, 8'h00);
      apb(1'b0, ADDR_CTRL, 8'h00);
      chk(rdat & 8'hBF, 8'h84);
      apb(1'b0, ADDR_COUNT_HI, 8'h00);
      chk(rdat, 8'h12);
      apb(1'b0, ADDR_IRQ_STATUS, 8'h00);
      chk(rdat & 8'h01, 8'h01);
      irq_en <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({7'h00, timer_req}, 8'h00);
      irq_en <= 1'b1;
      apb(1'b1, ADDR_IRQ_MASK, 8'h01);
      repeat (2) @(posedge mclk);
      chk({7'h00, irq}, 8'h01);
      apb(1'b1, ADDR_IRQ_STATUS, 8'h07);
      repeat (2) @(posedge mclk);
      chk({7'h00, irq}, 8'h00);
      repeat (40) @(posedge mclk);
      chk({7'h00, timer_req}, 8'h01);
      apb(1'b1, ADDR_CTRL, 8'h00);
      repeat (2) @(posedge mclk);
      chk({7'h00, timer_req}, 8'h00);
      $display("test reload16 done");

      // Low byte wrap interrupts only with its enable
      set_count(8'h00, 8'hFD);
      apb(1'b1, ADDR_CTRL, 8'h04);
      repeat (20) @(posedge mclk);
      chk({7'h00, timer_req}, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h24);
      wait_req(300);
      apb(1'b0, ADDR_CTRL, 8'h00);
      chk(rdat & 8'hC0, 8'h40);
      apb(1'b1, ADDR_CTRL, 8'h00);
      $display("test lowirq done");

      // Split mode: low runs alone, high gated by run bit
      apb(1'b1, ADDR_RELOAD_LO, 8'hF0);
      apb(1'b1, ADDR_RELOAD_HI, 8'h77);
      set_count(8'h40, 8'hFE);
      apb(1'b1, ADDR_CTRL, 8'h08);
      repeat (30) @(posedge mclk);
      apb(1'b0, ADDR_COUNT_HI, 8'h00);
      chk(rdat, 8'h40);
      apb(1'b0, ADDR_COUNT_LO, 8'h00);
      chk({7'h00, rdat >= 8'hF0}, 8'h01);
      apb(1'b0, ADDR_CTRL, 8'h00);
      chk(rdat & 8'hC0, 8'h40);
      chk({7'h00, timer_req}, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h0C);
      wait_req(300);
      apb(1'b0, ADDR_COUNT_HI, 8'h00);
      chk({7'h00, rdat >= 8'h77}, 8'h01);
      apb(1'b1, ADDR_CTRL, 8'h28);
      wait_req(40);
      apb(1'b1, ADDR_CTRL, 8'h00);
      $display("test split done");

      // Capture from frame start, then oscillator fall only
      set_count(8'hAB, 8'hCD);
      apb(1'b1, ADDR_CTRL, 8'h10);
      frame_start <= 1'b1;
      repeat (8) @(posedge mclk);
      apb(1'b0, ADDR_RELOAD_LO, 8'h00);
      chk(rdat, 8'hCD);
      apb(1'b0, ADDR_RELOAD_HI, 8'h00);
      chk(rdat, 8'hAB);
      apb(1'b0, ADDR_IRQ_STATUS, 8'h00);
      chk(rdat & 8'h04, 8'h04);
      chk({7'h00, timer_req}, 8'h01);
      frame_start <= 1'b0;
      set_count(8'h13, 8'h57);
      apb(1'b1, ADDR_CTRL, 8'h12);
      low_freq_osc <= 1'b1;
      repeat (8) @(posedge mclk);
      low_freq_osc <= 1'b0;
      repeat (8) @(posedge mclk);
      set_count(8'h24, 8'h68);
      frame_start <= 1'b1;
      repeat (8) @(posedge mclk);
      apb(1'b0, ADDR_RELOAD_LO, 8'h00);
      chk(rdat, 8'h57);
      apb(1'b0, ADDR_RELOAD_HI, 8'h00);
      chk(rdat, 8'h13);
      frame_start <= 1'b0;
      apb(1'b1, ADDR_CTRL, 8'h00);
      // Split capture: high held by run bit, low wraps to zero
      set_count(8'h9A, 8'hF0);
      apb(1'b1, ADDR_CTRL, 8'h18);
      frame_start <= 1'b1;
      repeat (24) @(posedge mclk);
      apb(1'b0, ADDR_RELOAD_HI, 8'h00);
      chk(rdat, 8'h9A);
      apb(1'b0, ADDR_RELOAD_LO, 8'h00);
      chk({7'h00, rdat > 8'hF0 && rdat < 8'hF8}, 8'h01);
      apb(1'b0, ADDR_COUNT_LO, 8'h00);
      chk({7'h00, rdat < 8'h30}, 8'h01);
      frame_start <= 1'b0;
      apb(1'b1, ADDR_CTRL, 8'h00);
      $display("test capture done");

      // Divided clocks: system over 12, external over 8
      apb(1'b1, ADDR_CLKSEL, 8'h00);
      set_count(8'h00, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h04);
      repeat (240) @(posedge mclk);
      apb(1'b1, ADDR_CTRL, 8'h00);
      apb(1'b0, ADDR_COUNT_LO, 8'h00);
      chk({7'h00, rdat >= 8'd20 && rdat <= 8'd21}, 8'h01);
      set_count(8'h00, 8'h00);
      apb(1'b1, ADDR_CTRL, 8'h05);
      repeat (640) @(posedge mclk);
      apb(1'b1, ADDR_CTRL, 8'h00);
      apb(1'b0, ADDR_COUNT_LO, 8'h00);
      chk({7'h00, rdat >= 8'd20 && rdat <= 8'd21}, 8'h01);
      $display("test dividers done");

      // Reset in mid-run returns registers and request to idle
      apb(1'b1, ADDR_CTRL, 8'h84);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk({7'h00, timer_req}, 8'h00);
      apb(1'b0, ADDR_CTRL, 8'h00);
      chk(rdat, CTRL_RESET);
      apb(1'b0, ADDR_COUNT_LO, 8'h00);
      chk(rdat, BYTE_RESET);
      $display("test reset done");
      end_of_test;
   end
endmodule

// ---- src/edge_sync.sv ----
// Two-stage synchroniser with falling-edge pulse output
`timescale 1ns/1ps
module edge_sync (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      fall_o
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // ****************************************************************
   // Synchroniser and edge detector
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign fall_o  = last_r & ~sync_r;
endmodule

// ---- src/pulse_divider.sv ----
// Divider producing a one-cycle enable every DIV qualifying ticks
`timescale 1ns/1ps
module pulse_divider #(
   parameter int DIV = 12
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic tick_i,
   output logic      pulse_o
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_r;

   // ****************************************************************
   // Modulo counter
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (tick_i) begin
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end

   assign pulse_o = tick_i & (cnt_r == LAST);
endmodule

// ---- src/reload_capture_timer.sv ----
// Reload and capture timer with APB register access
`timescale 1ns/1ps
// Overview of operation
// (R01) Split and capture clear: 16-bit reload counter
// (R02) 16-bit wrap loads reload value, sets high flag
// (R03) 16-bit overflow requests interrupt when enabled
// (R04) Low-byte wrap also interrupts if low enable
// (R05) Split mode: two 8-bit reload counters
// (R06) Run bit gates high byte only in split
// (R07) Per-byte clock: system, /12, or external /8
// (R08) External clock synchronised before use
// (R09) Byte wraps set high and low flags
// (R10) Split interrupts: high, or either with enable
// (R11) Hardware never clears overflow flags
// (R12) Capture source: frame start or oscillator fall
// (R13) Capture 16-bit counts, latches into reload bytes
// (R14) Capture split: two 8-bit counters latched
// (R15) Run bit at position 2 stops or runs
// (R16) High flag set drives timer interrupt
// (R17) Request is high flag, gated low flag, or capture flag in capture
module reload_capture_timer (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic        ext_clk_i,
   input  wire logic        frame_start_i,
   input  wire logic        low_freq_osc_i,
   input  wire logic        timer_irq_en_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             timer_req_o,
   output logic             irq_o
);
   import reload_timer_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]  ctrl_r;
   logic [1:0]  clksel_r;
   logic [7:0]  count_lo_r;
   logic [7:0]  count_hi_r;
   logic [7:0]  reload_lo_r;
   logic [7:0]  reload_hi_r;
   logic [2:0]  stat_r;
   logic [2:0]  mask_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        timer_req_r;
   logic        irq_r;
   logic        sof_meta_r;
   logic        sof_sync_r;
   logic        sof_last_r;

   // ****************************************************************
   // Clock sources
   // ****************************************************************
   logic ext_fall;
   logic lfo_fall;
   logic sys_div_pulse;
   logic ext_div_pulse;

   edge_sync u_ext_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (ext_clk_i),
      .level_o (),
      .fall_o  (ext_fall)
   );

   edge_sync u_lfo_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (low_freq_osc_i),
      .level_o (),
      .fall_o  (lfo_fall)
   );

   pulse_divider #(.DIV(SYS_DIV)) u_sys_div (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .tick_i  (1'b1),
      .pulse_o (sys_div_pulse)
   );

   // see (R08)
   pulse_divider #(.DIV(EXT_DIV)) u_ext_div (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .tick_i  (ext_fall),
      .pulse_o (ext_div_pulse)
   );

   // ****************************************************************
   // Mode and tick decode
   // ****************************************************************
   wire         cap_en    = ctrl_r[CTRL_CAP_EN];
   wire         split     = ctrl_r[CTRL_SPLIT];
   wire         run       = ctrl_r[CTRL_RUN];          // see (R15)
   wire         lo_ien    = ctrl_r[CTRL_LO_IEN];
   timer_mode_t mode;
   assign mode = timer_mode_t'({cap_en, split});

   wire slow_tick = ctrl_r[CTRL_EXT_SEL] ? ext_div_pulse
                                         : sys_div_pulse; // see (R07)
   wire lo_src  = clksel_r[CLKSEL_LO] ? 1'b1 : slow_tick;  // see (R07)
   wire hi_src  = clksel_r[CLKSEL_HI] ? 1'b1 : slow_tick;  // see (R07)

   // Split: low always runs, high gated by run bit
   wire lo_tick = split ? lo_src : (run & lo_src);     // see (R06)
   wire lo_wrap = lo_tick & (count_lo_r == BYTE_MAX);
   wire hi_tick = split ? (run & hi_src) : lo_wrap;   // see (R01)
   wire hi_wrap = hi_tick & (count_hi_r == BYTE_MAX);
   wire reload_on = ~cap_en;

   // Capture event selection
   wire sof_rise  = sof_sync_r & ~sof_last_r;
   wire cap_event = cap_en & (ctrl_r[CTRL_CAP_SRC] ? lfo_fall
                                                   : sof_rise); // see (R12)

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire apb_setup = psel_i & ~penable_i;
   wire apb_acc   = psel_i & penable_i & pready_r;
   wire wr_en     = apb_acc & pwrite_i & pstrb_i[0];
   wire hit_ctrl  = (paddr_i == ADDR_CTRL);
   wire hit_rl_lo = (paddr_i == ADDR_RELOAD_LO);
   wire hit_rl_hi = (paddr_i == ADDR_RELOAD_HI);
   wire hit_cn_lo = (paddr_i == ADDR_COUNT_LO);
   wire hit_cn_hi = (paddr_i == ADDR_COUNT_HI);
   wire hit_clks  = (paddr_i == ADDR_CLKSEL);
   wire hit_stat  = (paddr_i == ADDR_IRQ_STATUS);
   wire hit_mask  = (paddr_i == ADDR_IRQ_MASK);
   wire mapped    = hit_ctrl | hit_rl_lo | hit_rl_hi | hit_cn_lo |
                    hit_cn_hi | hit_clks | hit_stat | hit_mask;
   wire [7:0] wbyte = pwdata_i[7:0];

   logic [7:0] rd_mux;
   assign rd_mux = hit_ctrl  ? ctrl_r :
                   hit_rl_lo ? reload_lo_r :
                   hit_rl_hi ? reload_hi_r :
                   hit_cn_lo ? count_lo_r :
                   hit_cn_hi ? count_hi_r :
                   hit_clks  ? {6'h00, clksel_r} :
                   hit_stat  ? {5'h00, stat_r} :
                   hit_mask  ? {5'h00, mask_r} : 8'h00;

   // ****************************************************************
   // Next-state for counters and flags
   // ****************************************************************
   logic [7:0] count_lo_nxt;
   logic [7:0] count_hi_nxt;
   logic [7:0] ctrl_nxt;
   logic [2:0] stat_nxt;

   always_comb begin
      count_lo_nxt = count_lo_r;
      count_hi_nxt = count_hi_r;
      if (lo_tick) begin
         count_lo_nxt = count_lo_r + 8'h01;
      end
      if (hi_tick) begin
         count_hi_nxt = count_hi_r + 8'h01;
      end
      case (mode)
         MODE_RELOAD16: begin
            if (hi_wrap) begin                        // see (R02)
               count_lo_nxt = reload_lo_r;
               count_hi_nxt = reload_hi_r;
            end
         end
         MODE_RELOAD8: begin
            if (lo_wrap) begin                        // see (R05)
               count_lo_nxt = reload_lo_r;
            end
            if (hi_wrap) begin                        // see (R05)
               count_hi_nxt = reload_hi_r;
            end
         end
         MODE_CAPT16: begin
         end                                          // see (R13)
         MODE_CAPT8: begin
         end                                          // see (R14)
         default: begin
         end
      endcase
      if (wr_en && hit_cn_lo) begin
         count_lo_nxt = wbyte;
      end
      if (wr_en && hit_cn_hi) begin
         count_hi_nxt = wbyte;
      end
   end

   // Flags: hardware set wins over software write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_en && hit_ctrl) begin
         ctrl_nxt = wbyte;
      end
      if (hi_wrap) begin
         ctrl_nxt[CTRL_HI_FLAG] = 1'b1;               // see (R09) (R11)
      end
      if (lo_wrap) begin
         ctrl_nxt[CTRL_LO_FLAG] = 1'b1;               // see (R09) (R11)
      end
   end

   always_comb begin
      stat_nxt = stat_r;
      if (wr_en && hit_stat) begin
         stat_nxt = stat_r & ~wbyte[2:0];
      end
      if (hi_wrap) begin
         stat_nxt[STAT_HI_OVF] = 1'b1;
      end
      if (lo_wrap) begin
         stat_nxt[STAT_LO_OVF] = 1'b1;
      end
      if (cap_event) begin
         stat_nxt[STAT_CAPTURE] = 1'b1;
      end
   end

   // Request: high flag, low flag when enabled, or capture flag in capture mode
   wire req_nxt = timer_irq_en_i &
                  (ctrl_nxt[CTRL_HI_FLAG] |
                   (ctrl_nxt[CTRL_LO_FLAG] & ctrl_nxt[CTRL_LO_IEN]) |
                   (cap_en & stat_nxt[STAT_CAPTURE])); // see (R13)
                                           // see (R03) (R04) (R10) (R16) (R17)
   wire irq_nxt = |(stat_nxt & mask_r);

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_r      <= CTRL_RESET;
         clksel_r    <= 2'h0;
         count_lo_r  <= BYTE_RESET;
         count_hi_r  <= BYTE_RESET;
         stat_r      <= STAT_RESET;
         mask_r      <= STAT_RESET;
         timer_req_r <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         count_lo_r  <= count_lo_nxt;
         count_hi_r  <= count_hi_nxt;
         stat_r      <= stat_nxt;
         timer_req_r <= req_nxt;
         irq_r       <= irq_nxt;
         if (wr_en && hit_clks) begin
            clksel_r <= wbyte[1:0];
         end
         if (wr_en && hit_mask) begin
            mask_r <= wbyte[2:0];
         end
      end
   end

   // Reload bytes: software write, or capture latch
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         reload_lo_r <= BYTE_RESET;
         reload_hi_r <= BYTE_RESET;
      end else if (cap_event) begin
         reload_lo_r <= count_lo_r;                   // see (R13) (R14)
         reload_hi_r <= count_hi_r;
      end else begin
         if (wr_en && hit_rl_lo) begin
            reload_lo_r <= wbyte;
         end
         if (wr_en && hit_rl_hi) begin
            reload_hi_r <= wbyte;
         end
      end
   end

   // Frame-start synchroniser, rising edge detected after stage two
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sof_meta_r <= 1'b0;
         sof_sync_r <= 1'b0;
         sof_last_r <= 1'b0;
      end else begin
         sof_meta_r <= frame_start_i;
         sof_sync_r <= sof_meta_r;
         sof_last_r <= sof_sync_r;
      end
   end

   // APB: no wait states, answer in first access cycle
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= apb_setup;
         pslverr_r <= apb_setup & ~mapped;
         if (apb_setup) begin
            prdata_r <= (~pwrite_i) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   assign prdata_o    = prdata_r;
   assign pready_o    = pready_r;
   assign pslverr_o   = pslverr_r;
   assign timer_req_o = timer_req_r;
   assign irq_o       = irq_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   hi_flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      hi_wrap |=> ctrl_r[CTRL_HI_FLAG])                 // see (R09)
      else $error("high flag not set on wrap");
   lo_flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      lo_wrap |=> ctrl_r[CTRL_LO_FLAG])                 // see (R09)
      else $error("low flag not set on wrap");
   reload16_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mode == MODE_RELOAD16 && hi_wrap && !wr_en)
      |=> {count_hi_r, count_lo_r} == $past({reload_hi_r, reload_lo_r}))
      else $error("16-bit reload not loaded");         // see (R02)
   reload8_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mode == MODE_RELOAD8 && lo_wrap && !wr_en)
      |=> count_lo_r == $past(reload_lo_r))             // see (R05)
      else $error("8-bit low reload not loaded");
   lo_free_run_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (split && !run && clksel_r[CLKSEL_LO] && !wr_en &&
       count_lo_r != BYTE_MAX)
      |=> count_lo_r == $past(count_lo_r) + 8'h01)      // see (R06)
      else $error("low byte stalled in split mode");
   hi_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!run && !wr_en) |=> $stable(count_hi_r))         // see (R15)
      else $error("high byte moved while stopped");
   capture_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      cap_event |=> reload_lo_r == $past(count_lo_r) &&
                    reload_hi_r == $past(count_hi_r))   // see (R13)
      else $error("capture did not latch count");
   cap_wrap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (mode == MODE_CAPT16 && hi_wrap && !wr_en)
      |=> {count_hi_r, count_lo_r} == 16'h0000)         // see (R13)
      else $error("capture count did not wrap to zero");
   flag_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ctrl_r[CTRL_HI_FLAG] && !(wr_en && hit_ctrl))
      |=> ctrl_r[CTRL_HI_FLAG])                         // see (R11)
      else $error("high flag cleared by hardware");
   req_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (timer_irq_en_i && ctrl_nxt[CTRL_HI_FLAG]) |=> timer_req_o)
      else $error("request missing with high flag");   // see (R16)
   apb_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      apb_setup |=> pready_o)
      else $error("apb answer late");

   cov_reload16_c: cover property (@(posedge mclk_i)
      mode == MODE_RELOAD16 && hi_wrap);
   cov_split_c: cover property (@(posedge mclk_i)
      mode == MODE_RELOAD8 && lo_wrap && hi_wrap);
   cov_capture_c: cover property (@(posedge mclk_i) cap_event);
   cov_irq_c: cover property (@(posedge mclk_i) irq_o && timer_req_o);
endmodule

// ---- src/reload_timer_pkg.sv ----
// Package of register map, field positions and timing constants
package reload_timer_pkg;

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL       = 8'hC8;
   localparam logic [7:0] ADDR_RELOAD_LO  = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_HI  = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_LO   = 8'hCC;
   localparam logic [7:0] ADDR_COUNT_HI   = 8'hCD;
   localparam logic [7:0] ADDR_CLKSEL     = 8'hD0;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hD4;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'hD8;

   // ****************************************************************
   // Control, clock-select and status register fields
   // ****************************************************************
   localparam int CTRL_HI_FLAG  = 7;
   localparam int CTRL_LO_FLAG  = 6;
   localparam int CTRL_LO_IEN   = 5;
   localparam int CTRL_CAP_EN   = 4;
   localparam int CTRL_SPLIT    = 3;
   localparam int CTRL_RUN      = 2;
   localparam int CTRL_CAP_SRC  = 1;
   localparam int CTRL_EXT_SEL  = 0;
   localparam int CLKSEL_HI     = 1;
   localparam int CLKSEL_LO     = 0;
   localparam int STAT_HI_OVF   = 0;
   localparam int STAT_LO_OVF   = 1;
   localparam int STAT_CAPTURE  = 2;

   // ****************************************************************
   // Reset values and dividers
   // ****************************************************************
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [2:0] STAT_RESET   = 3'h0;
   localparam int         SYS_DIV      = 12;
   localparam int         EXT_DIV      = 8;
   localparam logic [7:0] BYTE_MAX     = 8'hFF;

   typedef enum logic [1:0] {
      MODE_RELOAD16 = 2'b00,
      MODE_RELOAD8  = 2'b01,
      MODE_CAPT16   = 2'b10,
      MODE_CAPT8    = 2'b11
   } timer_mode_t;

endpackage
